// >>> rtl/epwm_output_stage.sv
// Enhanced PWM output stage with AXI4-Lite register slave
// ==========================================================
// Overview of operation
// [R1] PWM timing counts from system clock divided by four
// [R2] Reset releases pins, restores register defaults
// [R3] Mode field: 00 single,10 half,01/11 full
// [R4] Ten-bit duty on four outputs A-D
// [R5] Single mode drives only steered pins
// [R6] Pins unused by mode are released
// [R7] Low function bits select output polarity
// [R8] First enable waits for new period
// [R9] Zero mode-control register releases the pin
// [R10] Drive only where port direction is output
// [R11] Period = 4 clocks x (period+1) x prescale
// [R12] Width = clock x prescale x ten-bit duty
// [R13] Half-bridge: A pwm, B complement
// [R14] Half-bridge activation delayed by dead-band count
// [R15] Dead-band above duty keeps output inactive
// [R16] Forward: A active, D modulated, B,C inactive
// [R17] Reverse: C active, B modulated, A,D inactive
// [R18] Period match clears timer, sets, latches duty
// [R19] Duty double-buffered until period boundary
// [R20] Ten-bit time base match clears output
// [R21] Dead-band only on inactive-to-active edge
// [R22] Per-channel two-bit timer select field
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module epwm_output_stage
	import epwm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire epwm_axi_req_type axiReq,
	output epwm_axi_rsp_type axiRsp,
	output epwm_pins_type pins
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0] modeCtrl;
		logic [7:0] dutyHigh;
		logic [7:0] tselLow;
		logic [7:0] tselHigh;
		logic [7:0] period;
		logic [7:0] tctrl;
		logic [7:0] count;
		logic [7:0] deadband;
		logic [3:0] steer;
		logic [3:0] portDir;
		logic [9:0] dutyLatch;
		logic [3:0] presc;
		logic [1:0] phase;
		logic pwmRaw;
		logic running;
		logic [6:0] dbA;
		logic [6:0] dbB;
		logic [3:0] dbTick;
		logic [3:0] outLevel;
		logic [3:0] outEnable;
		logic awHeld;
		logic [ADDR_W-1:0] awAddr;
		logic wHeld;
		logic [DATA_W-1:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [DATA_W-1:0] rData;
		logic [1:0] rResp;
	} epwm_state_type;
	epwm_state_type state_r;
	epwm_state_type state_nxt;
	localparam epwm_state_type STATE_RST = '{
		modeCtrl: MODE_CTRL_RST, period: PERIOD_RST, tctrl: TCTRL_RST,
		steer: STEER_RST[3:0], portDir: PORTDIR_RST, default: '0};
	epwm_mode_type mode;
	logic pwmSel;
	logic [1:0] prescSel;
	logic [9:0] timeBase;
	logic tick;
	logic baseStep;
	logic periodEnd;
	logic [9:0] duty;
	logic pwmFunc;
	logic [3:0] useMask;
	logic [3:0] activeRaw;
	logic doWrite;
	logic [7:0] wByte;
	logic rdHit;
	logic [7:0] rdByte;
	assign mode = epwm_mode_type'(state_r.modeCtrl[7:6]); // [R3]
	assign pwmFunc = state_r.modeCtrl[3:2] == PWM_FUNC;
	assign duty = {state_r.dutyHigh, state_r.modeCtrl[5:4]}; // [R12]
	// Channel zero of the shared timers; only this block's own timer exists here
	assign pwmSel = state_r.tselLow[1:0] == 2'h0; // [R22]
	assign prescSel = state_r.tctrl[1:0];
	// ==========================================================
	// Time base
	always_comb begin
		unique case (prescSel)
			PRESC_1: tick = 1'b1;
			PRESC_4: tick = state_r.presc[1:0] == 2'h3;
			default: tick = state_r.presc == 4'hF;
		endcase
		// Low two bits: raw clock phase at 1:1, else prescaler bits [R20]
		unique case (prescSel)
			PRESC_1: timeBase = {state_r.count, state_r.phase};
			PRESC_4: timeBase = {state_r.count, state_r.presc[1:0]};
			default: timeBase = {state_r.count, state_r.presc[3:2]};
		endcase
		periodEnd = tick && state_r.phase == 2'h3 && state_r.count == state_r.period; // [R11]
		// Time base advances on this clock; used to end the pulse on the step into the match
		unique case (prescSel)
			PRESC_1: baseStep = 1'b1;
			PRESC_4: baseStep = state_r.phase == 2'h3;
			default: baseStep = state_r.phase == 2'h3 && state_r.presc[1:0] == 2'h3;
		endcase
	end
	// ==========================================================
	// Pin mapping
	always_comb begin
		unique case (mode)
			EPWM_SINGLE: useMask = state_r.steer; // [R5]
			EPWM_HALF: useMask = 4'h3; // [R13]
			default: useMask = 4'hF;
		endcase
		unique case (mode)
			EPWM_SINGLE: activeRaw = {4{state_r.pwmRaw}};
			EPWM_HALF: activeRaw = {2'b00, state_r.pwmRaw ? 1'b0 : state_r.dbB == 7'h0,
				state_r.pwmRaw && state_r.dbA == 7'h0}; // [R14] [R15] [R21]
			EPWM_FULL_FWD: activeRaw = {state_r.pwmRaw, 2'b00, 1'b1}; // [R16]
			EPWM_FULL_REV: activeRaw = {1'b0, 1'b1, state_r.pwmRaw, 1'b0}; // [R17]
		endcase
	end
	// ==========================================================
	// Register access
	assign doWrite = state_r.awHeld && state_r.wHeld && !state_r.bValid;
	assign wByte = state_r.wData[7:0];
	always_comb begin
		rdHit = 1'b1;
		unique case (axiReq.araddr)
			OFF_MODE_CTRL: rdByte = state_r.modeCtrl;
			OFF_DUTY_HIGH: rdByte = state_r.dutyHigh;
			OFF_TSEL_LOW: rdByte = state_r.tselLow;
			OFF_TSEL_HIGH: rdByte = {6'h00, state_r.tselHigh[1:0]};
			OFF_PERIOD: rdByte = state_r.period;
			OFF_TCTRL: rdByte = {1'b0, state_r.tctrl[6:0]};
			OFF_COUNT: rdByte = state_r.count;
			OFF_DEADBAND: rdByte = {1'b0, state_r.deadband[6:0]};
			OFF_STEER: rdByte = {4'h0, state_r.steer};
			OFF_PORTDIR: rdByte = {4'h0, state_r.portDir};
			OFF_DUTYLAT: rdByte = state_r.dutyLatch[9:2];
			default: begin
				rdByte = 8'h00;
				rdHit = 1'b0;
			end
		endcase
	end
	// ==========================================================
	// Next state
	always_comb begin
		state_nxt = state_r;
		// Timer and prescaler run only while enabled [R1]
		if (state_r.tctrl[TCTRL_ON_BIT]) begin
			state_nxt.phase = state_r.phase + 2'h1;
			if (state_r.phase == 2'h3) begin
				state_nxt.presc = tick ? 4'h0 : state_r.presc + 4'h1;
				if (tick) begin
					state_nxt.count = periodEnd ? 8'h00 : state_r.count + 8'h01; // [R18]
				end
			end
		end
		// Free count first, so the restarts at boundary and match below win [R14]
		if (state_r.dbTick == OSC_PER_INSTR - 4'h1) begin
			state_nxt.dbTick = 4'h0;
			if (state_r.dbA != 7'h0 && state_r.pwmRaw) begin
				state_nxt.dbA = state_r.dbA - 7'h1;
			end
			if (state_r.dbB != 7'h0 && !state_r.pwmRaw) begin
				state_nxt.dbB = state_r.dbB - 7'h1;
			end
		end else begin
			state_nxt.dbTick = state_r.dbTick + 4'h1;
		end
		// Period boundary: set output and reload duty [R18] [R19]
		if (state_r.tctrl[TCTRL_ON_BIT] && periodEnd && pwmSel) begin
			state_nxt.dutyLatch = duty; // [R19]
			state_nxt.running = pwmFunc; // [R8]
			state_nxt.pwmRaw = pwmFunc && duty != 10'h000; // [R18]
			state_nxt.dbA = state_r.deadband[6:0]; // [R14]
			state_nxt.dbTick = 4'h0;
		// Clearing one step early offsets the register delay; on the match itself it adds one
		end else if (state_r.pwmRaw && baseStep && timeBase + 10'h001 == state_r.dutyLatch) begin
			state_nxt.pwmRaw = 1'b0; // [R20]
			state_nxt.dbB = state_r.deadband[6:0]; // [R21]
			state_nxt.dbTick = 4'h0;
		end
		if (!pwmFunc) begin
			state_nxt.running = 1'b0; // [R8]
			state_nxt.pwmRaw = 1'b0;
		end
		// Polarity: function bit 1 inverts A/C, bit 0 inverts B/D [R7]
		state_nxt.outLevel = activeRaw ^ {state_r.modeCtrl[0], state_r.modeCtrl[1],
			state_r.modeCtrl[0], state_r.modeCtrl[1]};
		// Drive only used pins, PWM enabled, direction output [R6] [R9] [R10]
		state_nxt.outEnable = (pwmFunc && state_r.running) ? (useMask & ~state_r.portDir) : 4'h0;
		// AXI write channels accepted independently
		if (axiReq.awvalid && !state_r.awHeld) begin
			state_nxt.awHeld = 1'b1;
			state_nxt.awAddr = axiReq.awaddr;
		end
		if (axiReq.wvalid && !state_r.wHeld) begin
			state_nxt.wHeld = 1'b1;
			state_nxt.wData = axiReq.wdata;
			state_nxt.wStrb = axiReq.wstrb;
		end
		if (doWrite) begin
			state_nxt.awHeld = 1'b0;
			state_nxt.wHeld = 1'b0;
			state_nxt.bValid = 1'b1;
			state_nxt.bResp = RESP_OKAY;
			if (state_r.wStrb[0]) begin
				unique case (state_r.awAddr)
					OFF_MODE_CTRL: state_nxt.modeCtrl = wByte; // [R9]
					OFF_DUTY_HIGH: state_nxt.dutyHigh = wByte; // [R19]
					OFF_TSEL_LOW: state_nxt.tselLow = wByte; // [R22]
					OFF_TSEL_HIGH: state_nxt.tselHigh = {6'h00, wByte[1:0]};
					OFF_PERIOD: state_nxt.period = wByte;
					OFF_TCTRL: state_nxt.tctrl = {1'b0, wByte[6:0]};
					OFF_COUNT: state_nxt.count = wByte;
					OFF_DEADBAND: state_nxt.deadband = {1'b0, wByte[6:0]};
					OFF_STEER: state_nxt.steer = wByte[3:0];
					OFF_PORTDIR: state_nxt.portDir = wByte[3:0];
					OFF_DUTYLAT: state_nxt.bResp = RESP_OKAY;
					default: state_nxt.bResp = RESP_SLVERR;
				endcase
			end
		end
		if (state_r.bValid && axiReq.bready) begin
			state_nxt.bValid = 1'b0;
		end
		if (axiReq.arvalid && !state_r.rValid) begin
			state_nxt.rValid = 1'b1;
			state_nxt.rData = {24'h000000, rdByte};
			state_nxt.rResp = rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (state_r.rValid && axiReq.rready) begin
			state_nxt.rValid = 1'b0;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_r <= STATE_RST; // [R2]
		end else begin
			state_r <= state_nxt;
		end
	end
	// ==========================================================
	// Outputs
	assign pins.outLevel = state_r.outLevel;
	assign pins.outEnable = state_r.outEnable;
	always_comb begin
		axiRsp.awready = !state_r.awHeld;
		axiRsp.wready = !state_r.wHeld;
		axiRsp.bvalid = state_r.bValid;
		axiRsp.bresp = state_r.bResp;
		axiRsp.arready = !state_r.rValid;
		axiRsp.rvalid = state_r.rValid;
		axiRsp.rdata = state_r.rData;
		axiRsp.rresp = state_r.rResp;
	end
	// ==========================================================
	// Assertions
	a_reset_release: assert property (@(posedge sys_clk) $past(reset) |-> pins.outEnable == 4'h0) // [R2]
		else $error("pins driven right after reset");
	a_dir_gate: assert property (@(posedge sys_clk) disable iff (reset) // [R10]
		(pins.outEnable & $past(state_r.portDir)) == 4'h0)
		else $error("pin driven while direction is input");
	a_zero_release: assert property (@(posedge sys_clk) disable iff (reset) // [R9]
		$past(state_r.modeCtrl) == 8'h00 |-> pins.outEnable == 4'h0)
		else $error("pin driven with mode control cleared");
	a_half_unused: assert property (@(posedge sys_clk) disable iff (reset) // [R13]
		$past(mode) == EPWM_HALF |-> pins.outEnable[3:2] == 2'b00)
		else $error("half bridge drives C or D");
	a_fwd_levels: assert property (@(posedge sys_clk) disable iff (reset) // [R16]
		$past(mode) == EPWM_FULL_FWD && $past(state_r.modeCtrl[1:0]) == 2'b00
		|-> pins.outLevel[0] && !pins.outLevel[1] && !pins.outLevel[2])
		else $error("forward mode levels wrong");
	a_rev_levels: assert property (@(posedge sys_clk) disable iff (reset) // [R17]
		$past(mode) == EPWM_FULL_REV && $past(state_r.modeCtrl[1:0]) == 2'b00
		|-> pins.outLevel[2] && !pins.outLevel[0] && !pins.outLevel[3])
		else $error("reverse mode levels wrong");
	a_duty_latch: assert property (@(posedge sys_clk) disable iff (reset) // [R19]
		state_r.tctrl[TCTRL_ON_BIT] && periodEnd && pwmSel |=> state_r.dutyLatch == $past(duty))
		else $error("duty not latched at period end");
	a_duty_hold: assert property (@(posedge sys_clk) disable iff (reset) // [R19]
		!(periodEnd && state_r.tctrl[TCTRL_ON_BIT]) |=> $stable(state_r.dutyLatch))
		else $error("duty latch changed mid period");
	a_period_wrap: assert property (@(posedge sys_clk) disable iff (reset) // [R18]
		state_r.tctrl[TCTRL_ON_BIT] && periodEnd && !doWrite |=> state_r.count == 8'h00)
		else $error("timer not cleared at period end");
	a_zero_duty: assert property (@(posedge sys_clk) disable iff (reset) // [R18]
		state_r.tctrl[TCTRL_ON_BIT] && periodEnd && duty == 10'h000 |=> !state_r.pwmRaw)
		else $error("output set with zero duty");
	// ==========================================================
	// Sequences for multi-step checks
	sequence s_boundary;
		state_r.tctrl[TCTRL_ON_BIT] && periodEnd && pwmSel;
	endsequence
	sequence s_half_plain;
		mode == EPWM_HALF && state_r.modeCtrl[1:0] == 2'b00;
	endsequence
	sequence s_pwm_fall;
		state_r.pwmRaw ##1 !state_r.pwmRaw;
	endsequence
	sequence s_duty_match;
		state_r.pwmRaw && baseStep && timeBase + 10'h001 == state_r.dutyLatch;
	endsequence
	a_start_hold: assert property (@(posedge sys_clk) disable iff (reset) // [R8]
		!state_r.running && !(state_r.tctrl[TCTRL_ON_BIT] && periodEnd && pwmSel) |=> !state_r.running)
		else $error("output started inside a period");
	a_start_boundary: assert property (@(posedge sys_clk) disable iff (reset) // [R8]
		s_boundary ##0 pwmFunc |=> state_r.running)
		else $error("output not started at period start");
	a_idle_release: assert property (@(posedge sys_clk) disable iff (reset) // [R8]
		!state_r.running |=> pins.outEnable == 4'h0)
		else $error("pin driven before first full period");
	a_set_on_wrap: assert property (@(posedge sys_clk) disable iff (reset) // [R18]
		s_boundary ##0 pwmFunc && duty != 10'h000 |=> state_r.pwmRaw)
		else $error("output not set at period start");
	a_count_step: assert property (@(posedge sys_clk) disable iff (reset) // [R11]
		state_r.tctrl[TCTRL_ON_BIT] && prescSel == PRESC_1 && state_r.phase != 2'h3 && !doWrite
		|=> $stable(state_r.count))
		else $error("timer stepped inside an instruction cycle");
	a_timer_frozen: assert property (@(posedge sys_clk) disable iff (reset) // [R1]
		!state_r.tctrl[TCTRL_ON_BIT] && !doWrite |=> $stable(state_r.count))
		else $error("timer counted while off");
	a_duty_clear: assert property (@(posedge sys_clk) disable iff (reset) // [R20]
		s_duty_match ##0 !(state_r.tctrl[TCTRL_ON_BIT] && periodEnd && pwmSel) |=> !state_r.pwmRaw)
		else $error("output not cleared at duty match");
	a_half_comp: assert property (@(posedge sys_clk) disable iff (reset) // [R13]
		mode == EPWM_HALF |-> !(activeRaw[0] && activeRaw[1]))
		else $error("half bridge outputs active together");
	a_half_fall: assert property (@(posedge sys_clk) disable iff (reset) // [R21]
		s_half_plain ##0 s_pwm_fall ##0 s_half_plain |=> !pins.outLevel[0])
		else $error("dead band delayed a falling edge");
	a_half_a_delay: assert property (@(posedge sys_clk) disable iff (reset) // [R14]
		s_half_plain ##0 state_r.dbA != 7'h0 |=> !pins.outLevel[0])
		else $error("output A active inside dead band");
	a_half_b_delay: assert property (@(posedge sys_clk) disable iff (reset) // [R15]
		s_half_plain ##0 state_r.dbB != 7'h0 |=> !pins.outLevel[1])
		else $error("output B active inside dead band");
	a_db_reload: assert property (@(posedge sys_clk) disable iff (reset) // [R14]
		s_boundary |=> state_r.dbA == $past(state_r.deadband[6:0]))
		else $error("dead band not reloaded at period start");
	a_db_phase_a: assert property (@(posedge sys_clk) disable iff (reset) // [R14]
		s_boundary |=> state_r.dbTick == 4'h0)
		else $error("dead band phase not restarted at period start");
	a_db_phase_b: assert property (@(posedge sys_clk) disable iff (reset) // [R14]
		s_duty_match ##0 !(state_r.tctrl[TCTRL_ON_BIT] && periodEnd && pwmSel) |=> state_r.dbTick == 4'h0)
		else $error("dead band phase not restarted at duty match");
	a_single_steer: assert property (@(posedge sys_clk) disable iff (reset) // [R5]
		$past(mode) == EPWM_SINGLE |-> (pins.outEnable & ~$past(state_r.steer)) == 4'h0)
		else $error("single mode drives an unsteered pin");
	a_single_level: assert property (@(posedge sys_clk) disable iff (reset) // [R5]
		$past(mode) == EPWM_SINGLE && $past(state_r.modeCtrl[1:0]) == 2'b00
		|-> pins.outLevel == {4{$past(state_r.pwmRaw)}})
		else $error("single mode level differs from modulator");
	a_fwd_enable: assert property (@(posedge sys_clk) disable iff (reset) // [R16]
		$past(mode) == EPWM_FULL_FWD && $past(state_r.running) && $past(pwmFunc)
		&& $past(state_r.portDir) == 4'h0 |-> pins.outEnable == 4'hF)
		else $error("forward mode leaves a pin undriven");
	a_rev_enable: assert property (@(posedge sys_clk) disable iff (reset) // [R17]
		$past(mode) == EPWM_FULL_REV && $past(state_r.running) && $past(pwmFunc)
		&& $past(state_r.portDir) == 4'h0 |-> pins.outEnable == 4'hF)
		else $error("reverse mode leaves a pin undriven");
	a_half_enable: assert property (@(posedge sys_clk) disable iff (reset) // [R13]
		$past(mode) == EPWM_HALF && $past(state_r.running) && $past(pwmFunc)
		&& $past(state_r.portDir) == 4'h0 |-> pins.outEnable == 4'h3)
		else $error("half bridge does not drive A and B");
endmodule

// >>> rtl/epwm_pkg.sv
// Package: register map, field layout and timing constants of the enhanced PWM output stage
package epwm_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_MODE_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_DUTY_HIGH = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_TSEL_LOW = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_TSEL_HIGH = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_PERIOD = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_TCTRL = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_DEADBAND = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_STEER = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_PORTDIR = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_DUTYLAT = 8'h28;
	localparam logic [7:0] MODE_CTRL_RST = 8'h00;
	localparam logic [7:0] PERIOD_RST = 8'hFF;
	localparam logic [7:0] TCTRL_RST = 8'h00;
	localparam logic [7:0] STEER_RST = 8'h01;
	localparam logic [3:0] PORTDIR_RST = 4'hF;
	localparam logic [1:0] PWM_FUNC = 2'h3;
	localparam int TCTRL_ON_BIT = 2;
	localparam logic [1:0] PRESC_1 = 2'h0;
	localparam logic [1:0] PRESC_4 = 2'h1;
	localparam logic [3:0] OSC_PER_INSTR = 4'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		EPWM_SINGLE = 2'b00,
		EPWM_FULL_FWD = 2'b01,
		EPWM_HALF = 2'b10,
		EPWM_FULL_REV = 2'b11
	} epwm_mode_type;
	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic awvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [ADDR_W-1:0] araddr;
		logic arvalid;
		logic rready;
	} epwm_axi_req_type;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} epwm_axi_rsp_type;
	typedef struct packed {
		logic [3:0] outLevel;
		logic [3:0] outEnable;
	} epwm_pins_type;
endpackage

// >>> verification/epwm_switch_model.sv
// Power switch driver model: pad levels, active-cycle counts, bridge overlap flag
`timescale 1ns/1ps
module epwm_switch_model
	import epwm_pkg::*;
(
	input wire logic sys_clk,
	input wire epwm_pins_type pins,
	input wire logic clearCnt,
	output logic [3:0] padLevel,
	output logic [3:0][7:0] highCnt,
	output logic overlap
);
	// ==========================================
	// Pads and counters
	// Released pad shows the inverse of its last level, so a stale value never passes
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < 4; i++) begin
			padLevel[i] <= pins.outEnable[i] ? pins.outLevel[i] : ~padLevel[i];
			if (clearCnt) begin
				highCnt[i] <= 8'h00;
			end else if (pins.outEnable[i] && pins.outLevel[i]) begin
				highCnt[i] <= highCnt[i] + 8'h01;
			end
		end
		// Both switches of the half bridge on at once means shoot-through
		if (clearCnt) begin
			overlap <= 1'b0;
		end else if (&(pins.outEnable[1:0] & pins.outLevel[1:0])) begin
			overlap <= 1'b1;
		end
	end
endmodule

// >>> verification/tb_top.sv
// Self-checking bench of the enhanced PWM output stage
`timescale 1ns/1ps
module tb_top
	import epwm_pkg::*;
;
	logic sys_clk;
	logic reset;
	logic clearCnt;
	epwm_axi_req_type axiReq;
	epwm_axi_rsp_type axiRsp;
	epwm_pins_type pins;
	logic [3:0][7:0] highCnt;
	logic overlap;
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;

	epwm_output_stage dut (.sys_clk(sys_clk), .reset(reset), .axiReq(axiReq), .axiRsp(axiRsp), .pins(pins));
	epwm_switch_model sw (.sys_clk(sys_clk), .pins(pins), .clearCnt(clearCnt), .padLevel(),
		.highCnt(highCnt), .overlap(overlap));

	// ==========================================
	// Clock, timeout, report
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic final_report();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			final_report();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// ==========================================
	// Register bus master
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		logic awT, wT, bT;
		@(posedge sys_clk);
		axiReq.awaddr <= a;
		axiReq.wdata <= d;
		axiReq.wstrb <= 4'hF;
		axiReq.awvalid <= 1'b1;
		axiReq.wvalid <= 1'b1;
		axiReq.bready <= 1'b1;
		forever begin
			@(negedge sys_clk);
			awT = axiReq.awvalid & axiRsp.awready;
			wT = axiReq.wvalid & axiRsp.wready;
			bT = axiRsp.bvalid;
			@(posedge sys_clk);
			if (awT) axiReq.awvalid <= 1'b0;
			if (wT) axiReq.wvalid <= 1'b0;
			if (bT) begin
				axiReq.bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic arT, rT;
		@(posedge sys_clk);
		axiReq.araddr <= a;
		axiReq.arvalid <= 1'b1;
		axiReq.rready <= 1'b1;
		forever begin
			@(negedge sys_clk);
			arT = axiReq.arvalid & axiRsp.arready;
			rT = axiRsp.rvalid;
			d = axiRsp.rdata;
			r = axiRsp.rresp;
			@(posedge sys_clk);
			if (arT) axiReq.arvalid <= 1'b0;
			if (rT) begin
				axiReq.rready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic check_reg(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] expResp);
		logic [31:0] d;
		logic [1:0] r;
		axi_read(a, d, r);
		check({30'h0, r}, {30'h0, expResp});
		if (expResp === RESP_OKAY) check(d, exp);
	endtask

	// ==========================================
	// Waveform helpers
	// Period 4 counts of 4 clocks = 16 clocks, duty 8 = 8 clocks
	task automatic setup(input logic [7:0] modeCtl, input logic [3:0] steer, input logic [6:0] dead);
		axi_write(OFF_PERIOD, 32'h3);
		axi_write(OFF_DUTY_HIGH, 32'h2);
		axi_write(OFF_DEADBAND, {25'h0, dead});
		axi_write(OFF_STEER, {28'h0, steer});
		axi_write(OFF_PORTDIR, 32'h0);
		axi_write(OFF_TCTRL, 32'h4);
		axi_write(OFF_MODE_CTRL, {24'h0, modeCtl});
		repeat (40) @(posedge sys_clk);
	endtask

	// Four whole periods, so the count is independent of phase
	task automatic measure(input logic [3:0] en, input logic [3:0][7:0] e, input logic ovl);
		@(posedge sys_clk);
		clearCnt <= 1'b1;
		@(posedge sys_clk);
		clearCnt <= 1'b0;
		repeat (64) @(posedge sys_clk);
		@(negedge sys_clk);
		check({28'h0, pins.outEnable}, {28'h0, en});
		for (int i = 0; i < 4; i++) check({24'h0, highCnt[i]}, {24'h0, e[i]});
		check({31'h0, overlap}, {31'h0, ovl});
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		check({28'h0, pins.outEnable}, 32'h0);
		check_reg(OFF_MODE_CTRL, 32'h0, RESP_OKAY);
		check_reg(OFF_PERIOD, 32'hFF, RESP_OKAY);
		check_reg(OFF_STEER, 32'h1, RESP_OKAY);
		check_reg(OFF_PORTDIR, 32'hF, RESP_OKAY);
		check_reg(OFF_TCTRL, 32'h0, RESP_OKAY);
		check_reg(8'h30, 32'h0, RESP_SLVERR);
		axi_write(OFF_DUTYLAT, 32'hAB);
		check_reg(OFF_DUTYLAT, 32'h0, RESP_OKAY);
	endtask

	task automatic t_single();
		setup(8'h0C, 4'h5, 7'h0);
		measure(4'h5, {8'd0, 8'd32, 8'd0, 8'd32}, 1'b0);
		axi_write(OFF_PORTDIR, 32'h4);
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		check({28'h0, pins.outEnable}, 32'h1);
	endtask

	task automatic t_half();
		setup(8'h8C, 4'h1, 7'h1);
		measure(4'h3, {8'd0, 8'd0, 8'd16, 8'd16}, 1'b0);
		axi_write(OFF_DEADBAND, 32'h3);
		repeat (40) @(posedge sys_clk);
		measure(4'h3, {8'd0, 8'd0, 8'd0, 8'd0}, 1'b0);
	endtask

	task automatic t_full();
		setup(8'h4C, 4'h1, 7'h0);
		measure(4'hF, {8'd32, 8'd0, 8'd0, 8'd64}, 1'b0);
		setup(8'hCC, 4'h1, 7'h0);
		measure(4'hF, {8'd0, 8'd64, 8'd32, 8'd0}, 1'b0);
		setup(8'h4F, 4'h1, 7'h0);
		measure(4'hF, {8'd32, 8'd64, 8'd64, 8'd0}, 1'b0);
		axi_write(OFF_MODE_CTRL, 32'h0);
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		check({28'h0, pins.outEnable}, 32'h0);
	endtask

	initial begin
		axiReq = '0;
		clearCnt = 1'b0;
		reset = 1'b1;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		@(negedge sys_clk);
		t_reset();
		t_single();
		t_half();
		t_full();
		final_report();
	end
endmodule
